// ### design/dimc_pkg.sv
// Constants, carrier structs and state layout of the direct input mode
// control block.
// Assumes a single 200 MHz clock and an AXI4-Lite register bus.
`default_nettype none
package dimc_pkg;

  // Channel count and supply grouping
  localparam int unsigned NUM_CH = 8;
  localparam logic [7:0] EVEN_GROUP_MASK = 8'h55;
  localparam logic [7:0] ODD_GROUP_MASK = 8'hAA;

  // Register byte addresses
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FIRST_MAP = 8'h04;
  localparam logic [7:0] ADDR_SECOND_MAP = 8'h08;
  localparam logic [7:0] ADDR_INPUT_MON = 8'h0C;
  localparam logic [7:0] ADDR_MODE_STAT = 8'h10;

  // Values after reset and while forced to default
  localparam logic [7:0] OUT_CTRL_DEF = 8'h00;
  localparam logic [7:0] FIRST_MAP_DEF = 8'h04;
  localparam logic [7:0] SECOND_MAP_DEF = 8'h08;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operating modes
  typedef enum logic [1:0] {
    DIMC_NORMAL,
    DIMC_SLEEP,
    DIMC_LIMP
  } dimc_mode_t;

  // Register selection from a bus address
  typedef enum logic [2:0] {
    SEL_OUT,
    SEL_FIRST_MAP,
    SEL_SECOND_MAP,
    SEL_INPUT_MON,
    SEL_MODE,
    SEL_NONE
  } dimc_sel_t;

  // Control pins travelling together through the synchroniser
  typedef struct packed {
    logic standby;
    logic second_direct_input;
    logic first_direct_input;
  } dimc_pins_t;

  // Synchroniser state
  typedef struct packed {
    dimc_pins_t q1;
    dimc_pins_t q2;
  } dimc_sync_t;

  localparam dimc_sync_t DIMC_SYNC_RST = '{q1: '0, q2: '0};

  // Main block state
  typedef struct packed {
    dimc_mode_t mode;
    logic [7:0] out_ctrl;
    logic [7:0] first_input_channel_map;
    logic [7:0] second_input_channel_map;
    logic [1:0] input_level_monitor;
    logic [7:0] drive;
    logic even_grp;
    logic odd_grp;
    logic uv_det_en;
    logic uv_flag;
    logic serial_en;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dimc_state_t;

  localparam dimc_state_t DIMC_STATE_RST = '{
    mode: DIMC_SLEEP,
    out_ctrl: OUT_CTRL_DEF,
    first_input_channel_map: FIRST_MAP_DEF,
    second_input_channel_map: SECOND_MAP_DEF,
    bresp: RESP_OKAY,
    rresp: RESP_OKAY,
    rdata: 32'h0000_0000,
    default: '0
  };

endpackage
`default_nettype wire

// ### design/dimc_sync.sv
// Two-stage synchroniser for the direct input pins and the standby pin.
// Assumes the pins may change at any time relative to aclk.
`timescale 1ns/10ps
`default_nettype none
module dimc_sync
  import dimc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire dimc_pins_t pins_in,
  output var dimc_pins_t pins_out
);

  dimc_sync_t s_ff;
  dimc_sync_t nxt_s;

  // First stage feeds only the second stage
  always_comb begin
    nxt_s = s_ff;
    nxt_s.q1 = pins_in; // R14
    nxt_s.q2 = s_ff.q1; // R14
  end

  // Frozen while the clock enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= DIMC_SYNC_RST;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign pins_out = s_ff.q2;

endmodule
`default_nettype wire

// ### design/dimc_top.sv
// Direct input mode control: input mapping, input level monitor, mode
// selection from the standby pin and register access over AXI4-Lite.
// Assumes pins are asynchronous to aclk and the bus master obeys AXI4-Lite.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: After reset the first input drives channel 2 and the second channel 3.
// R2: Each input has its own software-writable channel map register.
// R3: A channel is on if its control bit or any input mapped to it is high.
// R4: The current level of each input pin is readable in a monitor register.
// R5: The monitor keeps updating in limp home mode as in normal operation.
// R6: Standby low with an input high enters limp home, default channels on.
// R7: Standby low with both inputs low enters sleep mode.
// R8: The host holds the standby pin for the entry and wake minimum times.
// R9: While standby is low all accessible registers are held at default; the code holds only the output control and the two map registers.
// R10: In sleep undervoltage detection is off and gives no indication.
// R11: In sleep the serial port ignores transfers and stays disabled.
// R12: Eight channels; even ones form one supply group, odd ones the other.
// R13: A logic undervoltage blocks access and resets registers to default.
// R14: Inputs and standby pass two flip-flop stages before use.
// R15: In limp home the drive comes only from the default mapping.
module dimc_top
  import dimc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic first_direct_input,
  input wire logic second_direct_input,
  input wire logic standby_pin,
  input wire logic vdd_uv_raw,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic [7:0] channel_drive,
  output logic [1:0] op_mode,
  output logic even_group_on,
  output logic odd_group_on,
  output logic uv_detect_en,
  output logic uv_indication,
  output logic serial_port_en
);

  dimc_state_t s_ff;
  dimc_state_t nxt_s;
  dimc_pins_t raw_pins;
  dimc_pins_t pins;
  logic do_write;
  logic wr_block;
  logic hold_dflt;
  dimc_sel_t wsel;
  dimc_sel_t rsel;

  // Address decode shared by the read and the write path
  function automatic dimc_sel_t reg_sel(input logic [7:0] addr);
    case (addr)
      ADDR_OUT_CTRL: reg_sel = SEL_OUT;
      ADDR_FIRST_MAP: reg_sel = SEL_FIRST_MAP;
      ADDR_SECOND_MAP: reg_sel = SEL_SECOND_MAP;
      ADDR_INPUT_MON: reg_sel = SEL_INPUT_MON;
      ADDR_MODE_STAT: reg_sel = SEL_MODE;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction

  // OR of control bits and mapped inputs, per channel
  function automatic logic [7:0] chan_or(
    input logic [7:0] out_bits,
    input logic [7:0] map_a,
    input logic [7:0] map_b,
    input logic in_a,
    input logic in_b
  );
    chan_or = out_bits | (map_a & {NUM_CH{in_a}}) | (map_b & {NUM_CH{in_b}});
  endfunction

  // Read data for a selected register; narrow fields sit in the low bits
  function automatic logic [31:0] read_word(
    input dimc_sel_t sel,
    input dimc_state_t st
  );
    case (sel)
      SEL_OUT: read_word = {24'h00_0000, st.out_ctrl};
      SEL_FIRST_MAP: read_word = {24'h00_0000, st.first_input_channel_map};
      SEL_SECOND_MAP: read_word = {24'h00_0000, st.second_input_channel_map};
      SEL_INPUT_MON: read_word = {30'h0000_0000, st.input_level_monitor};
      SEL_MODE: read_word = {30'h0000_0000, st.mode};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // Pins bundled and synchronised before any use
  assign raw_pins = '{standby: standby_pin,
                      second_direct_input: second_direct_input,
                      first_direct_input: first_direct_input};

  dimc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pins_in(raw_pins),
    .pins_out(pins)
  );

  // Next-state logic for mode, registers, drive and the bus slave
  always_comb begin
    nxt_s = s_ff;
    wsel = reg_sel(s_ff.aw_addr);
    rsel = reg_sel(araddr);

    // Mode from synchronised standby and inputs
    if (pins.standby) begin
      nxt_s.mode = DIMC_NORMAL;
    end else if (pins.first_direct_input || pins.second_direct_input) begin
      nxt_s.mode = DIMC_LIMP; // R6
    end else begin
      nxt_s.mode = DIMC_SLEEP; // R7
    end

    // Undervoltage detection only outside sleep
    nxt_s.uv_det_en = (nxt_s.mode != DIMC_SLEEP); // R10
    nxt_s.uv_flag = vdd_uv_raw && nxt_s.uv_det_en; // R10
    nxt_s.serial_en = (nxt_s.mode != DIMC_SLEEP); // R11

    // Sleep and undervoltage lock the port; limp writes are later overridden
    wr_block = (nxt_s.mode == DIMC_SLEEP) || s_ff.uv_flag; // R11 R13
    hold_dflt = !pins.standby || s_ff.uv_flag; // R9 R13

    // Address and data are taken independently, in either order
    if (awvalid && s_ff.awready) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_addr = awaddr;
    end
    if (wvalid && s_ff.wready) begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_data = wdata[7:0];
      nxt_s.w_strb0 = wstrb[0];
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end

    // Write commits once both halves are held and no answer is pending
    do_write = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
    if (do_write) begin
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = RESP_OKAY;
      if (wr_block) begin
        nxt_s.bresp = RESP_SLVERR; // R11 R13
      end else begin
        case (wsel)
          SEL_OUT: begin
            if (s_ff.w_strb0) begin
              nxt_s.out_ctrl = s_ff.w_data;
            end
          end
          SEL_FIRST_MAP: begin
            if (s_ff.w_strb0) begin
              nxt_s.first_input_channel_map = s_ff.w_data; // R2
            end
          end
          SEL_SECOND_MAP: begin
            if (s_ff.w_strb0) begin
              nxt_s.second_input_channel_map = s_ff.w_data; // R2
            end
          end
          default: begin
            nxt_s.bresp = RESP_SLVERR;
          end
        endcase
      end
    end

    // Forced defaults win over a write in the same cycle
    if (hold_dflt) begin
      nxt_s.out_ctrl = OUT_CTRL_DEF; // R9 R13
      nxt_s.first_input_channel_map = FIRST_MAP_DEF; // R1
      nxt_s.second_input_channel_map = SECOND_MAP_DEF; // R1
    end

    // Read path: one outstanding read, answer one cycle after acceptance
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      if (wr_block) begin
        nxt_s.rdata = 32'h0000_0000; // R11 R13
        nxt_s.rresp = RESP_SLVERR;
      end else if (rsel == SEL_NONE) begin
        nxt_s.rdata = 32'h0000_0000;
        nxt_s.rresp = RESP_SLVERR;
      end else begin
        nxt_s.rdata = read_word(rsel, s_ff);
        nxt_s.rresp = RESP_OKAY;
      end
    end

    // Ready flags registered so every bus output comes from a flop
    nxt_s.awready = !nxt_s.aw_held && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_held && !nxt_s.bvalid;
    nxt_s.arready = !nxt_s.rvalid;

    // Monitor follows the pins in every mode, limp home included
    nxt_s.input_level_monitor = {pins.second_direct_input,
                                 pins.first_direct_input}; // R4 R5

    // Channel drive; limp ignores registers that are about to be defaulted
    case (nxt_s.mode)
      DIMC_NORMAL: begin
        nxt_s.drive = chan_or(s_ff.out_ctrl, s_ff.first_input_channel_map,
                              s_ff.second_input_channel_map,
                              pins.first_direct_input,
                              pins.second_direct_input); // R3
      end
      DIMC_LIMP: begin
        nxt_s.drive = chan_or(OUT_CTRL_DEF, FIRST_MAP_DEF, SECOND_MAP_DEF,
                              pins.first_direct_input,
                              pins.second_direct_input); // R6 R15
      end
      DIMC_SLEEP: begin
        nxt_s.drive = 8'h00;
      end
      default: begin
        nxt_s.drive = 8'h00;
      end
    endcase

    // Supply group activity for the two battery feeds
    nxt_s.even_grp = |(nxt_s.drive & EVEN_GROUP_MASK); // R12
    nxt_s.odd_grp = |(nxt_s.drive & ODD_GROUP_MASK); // R12
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= DIMC_STATE_RST;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign awready = s_ff.awready;
  assign wready = s_ff.wready;
  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign arready = s_ff.arready;
  assign rvalid = s_ff.rvalid;
  assign rdata = s_ff.rdata;
  assign rresp = s_ff.rresp;
  assign channel_drive = s_ff.drive;
  assign op_mode = s_ff.mode;
  assign even_group_on = s_ff.even_grp;
  assign odd_group_on = s_ff.odd_grp;
  assign uv_detect_en = s_ff.uv_det_en;
  assign uv_indication = s_ff.uv_flag;
  assign serial_port_en = s_ff.serial_en;

  // Checks on the behaviour above
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Release edge excluded: the synchroniser is still being cleared there
  sequence s_first_held;
    aresetn && ce && first_direct_input ##1 ce && first_direct_input;
  endsequence

  sequence s_standby_low;
    ce && !pins.standby;
  endsequence

  sequence s_sleep_cond;
    ce && !pins.standby && !pins.first_direct_input &&
      !pins.second_direct_input;
  endsequence

  a_sync_two_stage: assert property ( // R14
    s_first_held |=> pins.first_direct_input
  ) else $error("first input not through two stages");

  a_default_maps: assert property ( // R1
    s_standby_low |=> s_ff.first_input_channel_map == 8'h04 &&
      s_ff.second_input_channel_map == 8'h08
  ) else $error("input maps not at default");

  a_forced_default: assert property ( // R9
    s_standby_low |=> s_ff.out_ctrl == OUT_CTRL_DEF
  ) else $error("output control not forced while standby low");

  a_map_write: assert property ( // R2
    ce && do_write && !wr_block && !hold_dflt && wsel == SEL_FIRST_MAP &&
      s_ff.w_strb0 |=> s_ff.first_input_channel_map == $past(s_ff.w_data)
  ) else $error("first map write lost");

  a_or_drive: assert property ( // R3
    ce && nxt_s.mode == DIMC_NORMAL |=> s_ff.drive ==
      ($past(s_ff.out_ctrl) |
       ($past(s_ff.first_input_channel_map) &
        {8{$past(pins.first_direct_input)}}) |
       ($past(s_ff.second_input_channel_map) &
        {8{$past(pins.second_direct_input)}}))
  ) else $error("channel drive is not the OR of sources");

  a_monitor_track: assert property ( // R4
    ce |=> s_ff.input_level_monitor ==
      {$past(pins.second_direct_input), $past(pins.first_direct_input)}
  ) else $error("input monitor does not follow pins");

  a_limp_monitor: assert property ( // R5
    ce && s_ff.mode == DIMC_LIMP ##1 ce |->
      s_ff.input_level_monitor[0] == $past(pins.first_direct_input)
  ) else $error("input monitor stalled in limp home");

  a_limp_entry: assert property ( // R6
    ce && !pins.standby && pins.first_direct_input |=>
      s_ff.mode == DIMC_LIMP && s_ff.drive[2]
  ) else $error("limp home not entered or channel 2 off");

  a_limp_default: assert property ( // R15
    ce && nxt_s.mode == DIMC_LIMP |=> (s_ff.drive & 8'hF3) == 8'h00
  ) else $error("limp home drive uses non-default mapping");

  a_sleep_entry: assert property ( // R7
    s_sleep_cond |=> s_ff.mode == DIMC_SLEEP && s_ff.drive == 8'h00
  ) else $error("sleep not entered");

  a_sleep_no_uv: assert property ( // R10
    s_sleep_cond |=> !s_ff.uv_det_en && !s_ff.uv_flag
  ) else $error("undervoltage active in sleep");

  a_sleep_no_port: assert property ( // R11
    s_sleep_cond ##0 do_write |=> s_ff.bresp == RESP_SLVERR &&
      !s_ff.serial_en
  ) else $error("serial transfer accepted in sleep");

  a_uv_reset: assert property ( // R13
    ce && s_ff.uv_flag |=> s_ff.out_ctrl == OUT_CTRL_DEF &&
      s_ff.second_input_channel_map == SECOND_MAP_DEF
  ) else $error("registers not reset on undervoltage");

  a_group_split: assert property ( // R12
    s_ff.odd_grp == |(s_ff.drive & 8'hAA) &&
      s_ff.even_grp == |(s_ff.drive & 8'h55)
  ) else $error("supply group flags disagree with drive");

endmodule
`default_nettype wire

// ### verif/dimc_host_model.sv
// Host model: drives the two direct inputs and the standby pin.
// Assumes commands come as a level held until done has been seen.
`timescale 1ns/10ps
`default_nettype none
module dimc_host_model
  import dimc_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = 6
)(
  input wire logic aclk,
  input wire logic cmd_valid,
  input wire dimc_pins_t cmd_pins,
  output logic cmd_done,
  output var dimc_pins_t pins
);
  logic [7:0] hold_cnt;
  // Pins start awake with both inputs low
  initial begin
    pins = '{standby: 1'b1, default: 1'b0};
    cmd_done = 1'b0;
    hold_cnt = 8'h00;
  end
  // Standby may not flip again before its minimum hold has run out
  always @(posedge aclk) begin
    cmd_done <= 1'b0;
    if (hold_cnt != 8'h00)
      hold_cnt <= hold_cnt - 8'h01;
    if (cmd_valid && !cmd_done && (hold_cnt == 8'h00 ||
        cmd_pins.standby == pins.standby)) begin
      pins <= cmd_pins;
      cmd_done <= 1'b1;
      if (cmd_pins.standby != pins.standby)
        hold_cnt <= HOLD_CYCLES[7:0];
    end
  end
endmodule
`default_nettype wire

// ### verif/direct_input_mode_control_test.sv
// Self-checking bench for the direct input mode control block.
// Assumes the host model drives the pins and this bench the register bus.
`timescale 1ns/10ps
`default_nettype none
module direct_input_mode_control_test
  import dimc_pkg::*;
;
  logic aclk, aresetn, ce, vdd_uv_raw, awvalid, awready, wvalid, wready;
  logic bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, channel_drive;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, op_mode;
  logic even_group_on, odd_group_on, uv_detect_en, uv_indication;
  logic serial_port_en, cmd_valid, cmd_done;
  dimc_pins_t cmd_pins, pins;
  int failures = 0;
  int samples_checked = 0;

  dimc_host_model #(.HOLD_CYCLES(6)) host (.aclk(aclk),
    .cmd_valid(cmd_valid), .cmd_pins(cmd_pins), .cmd_done(cmd_done),
    .pins(pins));
  dimc_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .first_direct_input(pins.first_direct_input),
    .second_direct_input(pins.second_direct_input),
    .standby_pin(pins.standby), .vdd_uv_raw(vdd_uv_raw),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .channel_drive(channel_drive), .op_mode(op_mode),
    .even_group_on(even_group_on), .odd_group_on(odd_group_on),
    .uv_detect_en(uv_detect_en), .uv_indication(uv_indication),
    .serial_port_en(serial_port_en));

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic close_out();
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic timed_out();
    failures++;
    close_out();
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_val({30'h0, got}, {30'h0, exp});
  endtask

  // Drive, mode and both group flags against one expected drive
  task automatic check_outs(input logic [7:0] drv, input dimc_mode_t m);
    check_val({24'h0, channel_drive}, {24'h0, drv});
    check_val({30'h0, op_mode}, {30'h0, m});
    check_val({31'h0, even_group_on}, {31'h0, |(drv & EVEN_GROUP_MASK)});
    check_val({31'h0, odd_group_on}, {31'h0, |(drv & ODD_GROUP_MASK)});
  endtask

  // Returns at the edge after the pins changed
  task automatic set_pins(input logic sb, input logic i1, input logic i0);
    int n;
    n = 0;
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd_pins <= '{standby: sb, second_direct_input: i1,
                  first_direct_input: i0};
    do begin
      @(posedge aclk);
      n++;
      if (n > 200)
        timed_out();
    end while (cmd_done !== 1'b1);
    cmd_valid <= 1'b0;
  endtask

  // Long enough for the two sync stages plus the state register
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
      if (n > 200)
        timed_out();
    end
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (n > 400)
        timed_out();
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check_resp(bresp, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    do begin
      @(posedge aclk);
      n++;
      if (n > 200)
        timed_out();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (n > 400)
        timed_out();
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check_resp(rresp, er);
    check_val(rdata, ed);
  endtask

  task automatic t_defaults();
    rd_chk(ADDR_FIRST_MAP, 32'h0000_0004, RESP_OKAY);
    rd_chk(ADDR_SECOND_MAP, 32'h0000_0008, RESP_OKAY);
    rd_chk(ADDR_OUT_CTRL, 32'h0000_0000, RESP_OKAY);
    rd_chk(ADDR_MODE_STAT, {30'h0, DIMC_NORMAL}, RESP_OKAY);
    set_pins(1'b1, 1'b1, 1'b1);
    settle();
    check_outs(8'h0C, DIMC_NORMAL);
  endtask

  // Pin change must not reach the drive before the third edge
  task automatic t_sync();
    set_pins(1'b1, 1'b0, 1'b0);
    settle();
    set_pins(1'b1, 1'b0, 1'b1);
    @(posedge aclk);
    #1;
    check_val({24'h0, channel_drive}, 32'h0000_0000);
    @(posedge aclk);
    #1;
    check_val({24'h0, channel_drive}, 32'h0000_0004);
  endtask

  task automatic t_mapping();
    wr_chk(ADDR_OUT_CTRL, 32'h0000_0041, RESP_OKAY);
    wr_chk(ADDR_FIRST_MAP, 32'h0000_0030, RESP_OKAY);
    wr_chk(ADDR_SECOND_MAP, 32'h0000_0080, RESP_OKAY);
    settle();
    check_outs(8'h71, DIMC_NORMAL);
    set_pins(1'b1, 1'b1, 1'b0);
    settle();
    check_outs(8'hC1, DIMC_NORMAL);
    wr_chk(ADDR_OUT_CTRL, 32'h0000_0000, RESP_OKAY);
    settle();
    check_outs(8'h80, DIMC_NORMAL);
    rd_chk(ADDR_INPUT_MON, 32'h0000_0002, RESP_OKAY);
  endtask

  // Refused writes leave the registers untouched
  task automatic t_refuse();
    wr_chk(8'h14, 32'h0000_00FF, RESP_SLVERR);
    wr_chk(ADDR_INPUT_MON, 32'h0000_0003, RESP_SLVERR);
    rd_chk(ADDR_OUT_CTRL, 32'h0000_0000, RESP_OKAY);
  endtask

  task automatic t_limp();
    set_pins(1'b0, 1'b0, 1'b1);
    settle();
    check_outs(8'h04, DIMC_LIMP);
    rd_chk(ADDR_FIRST_MAP, 32'h0000_0004, RESP_OKAY);
    wr_chk(ADDR_OUT_CTRL, 32'h0000_00FF, RESP_OKAY);
    settle();
    check_outs(8'h04, DIMC_LIMP);
    rd_chk(ADDR_OUT_CTRL, 32'h0000_0000, RESP_OKAY);
    set_pins(1'b0, 1'b1, 1'b0);
    settle();
    check_outs(8'h08, DIMC_LIMP);
    rd_chk(ADDR_INPUT_MON, 32'h0000_0002, RESP_OKAY);
  endtask

  // Undervoltage raised in sleep must not show
  task automatic t_sleep();
    set_pins(1'b0, 1'b0, 1'b0);
    vdd_uv_raw <= 1'b1;
    settle();
    check_outs(8'h00, DIMC_SLEEP);
    check_val({30'h0, uv_detect_en, uv_indication}, 32'h0000_0000);
    check_val({31'h0, serial_port_en}, 32'h0000_0000);
    wr_chk(ADDR_OUT_CTRL, 32'h0000_0001, RESP_SLVERR);
    rd_chk(ADDR_FIRST_MAP, 32'h0000_0000, RESP_SLVERR);
    @(posedge aclk);
    vdd_uv_raw <= 1'b0;
  endtask

  task automatic t_uv();
    set_pins(1'b1, 1'b0, 1'b0);
    settle();
    check_val({31'h0, uv_detect_en}, 32'h0000_0001);
    check_val({31'h0, serial_port_en}, 32'h0000_0001);
    wr_chk(ADDR_FIRST_MAP, 32'h0000_0010, RESP_OKAY);
    rd_chk(ADDR_FIRST_MAP, 32'h0000_0010, RESP_OKAY);
    @(posedge aclk);
    vdd_uv_raw <= 1'b1;
    settle();
    check_val({31'h0, uv_indication}, 32'h0000_0001);
    wr_chk(ADDR_SECOND_MAP, 32'h0000_0001, RESP_SLVERR);
    @(posedge aclk);
    vdd_uv_raw <= 1'b0;
    settle();
    rd_chk(ADDR_FIRST_MAP, 32'h0000_0004, RESP_OKAY);
  endtask

  // Clock enable low freezes the synchroniser and the drive
  task automatic t_freeze();
    @(posedge aclk);
    ce <= 1'b0;
    set_pins(1'b1, 1'b0, 1'b1);
    settle();
    check_val({24'h0, channel_drive}, 32'h0000_0000);
    @(posedge aclk);
    ce <= 1'b1;
    settle();
    check_val({24'h0, channel_drive}, 32'h0000_0004);
  endtask

  // Mid-run reset with an input high brings the maps back to default
  task automatic t_reset();
    wr_chk(ADDR_FIRST_MAP, 32'h0000_0020, RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    check_outs(8'h04, DIMC_NORMAL);
    rd_chk(ADDR_FIRST_MAP, 32'h0000_0004, RESP_OKAY);
  endtask

  // Main sequence
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    vdd_uv_raw = 1'b0;
    awvalid = 1'b0;
    awaddr = 8'h00;
    wvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 8'h00;
    rready = 1'b0;
    cmd_valid = 1'b0;
    cmd_pins = '{standby: 1'b1, default: 1'b0};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    t_defaults();
    t_sync();
    t_mapping();
    t_refuse();
    t_limp();
    t_sleep();
    t_uv();
    t_freeze();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
